// ==== pkg/power_link_pkg.sv ====
// Purpose: shared constants for the power and link startup sequencer
// Assumes: 20 MHz pclk, APB register access, 32-bit data
// Notes:   register offsets are byte addresses

package power_link_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ctrl_off    = 8'h00;
  localparam logic [7:0] link_off    = 8'h04;
  localparam logic [7:0] status_off  = 8'h08;
  localparam logic [7:0] strap_off   = 8'h0c;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int sleep_bit       = 0;
  localparam int cable_type_bit  = 1;
  localparam int latch_edge_bit  = 2;
  localparam int ctrl_proto_bit  = 3;
  localparam int wake_pos_bit    = 4;
  localparam int wake_neg_bit    = 5;

  // ****************************************
  // Link register fields
  // ****************************************
  localparam int cfg_link_bit    = 0;
  localparam int serial_link_bit = 1;
  localparam int rate_bit        = 2;
  localparam int width_bit       = 3;
  localparam int err_corr_bit    = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic wake_pos_reset = 1'b1;
  localparam logic wake_neg_reset = 1'b0;

  // ****************************************
  // Three-level strap codes
  // ****************************************
  localparam logic [1:0] lvl_low  = 2'h0;
  localparam logic [1:0] lvl_mid  = 2'h1;
  localparam logic [1:0] lvl_high = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int clk_mhz       = 20;
  localparam int chan_wait_ms  = 2;
  localparam int chan_wait_cyc = chan_wait_ms * 1000 * clk_mhz;
  localparam int lock_wait_ms  = 3;
  localparam int lock_wait_cyc = lock_wait_ms * 1000 * clk_mhz;
  localparam int osc_div       = 20;

  typedef enum logic [3:0] {
    link_off_st  = 4'b0001,
    link_cfg_st  = 4'b0010,
    link_lock_st = 4'b0100,
    link_vid_st  = 4'b1000
  } link_state_t;

endpackage

// ==== hdl/strap_decode.sv ====
// Purpose: decode two three-level straps into power-up defaults
// Assumes: straps given as 2-bit level codes
// Notes:   both-high leaves valid low

module strap_decode
(
  // Strap levels
  input  wire logic [1:0] strap_cfg_hi,
  input  wire logic [1:0] strap_cfg_lo,
  // Decoded defaults
  output logic            cable_type,
  output logic            latch_edge,
  output logic            ctrl_proto,
  output logic            valid
);

  logic [3:0] idx;

  always_comb
  begin
    idx        = {strap_cfg_hi, strap_cfg_lo};
    cable_type = 1'b0;
    latch_edge = 1'b0;
    ctrl_proto = 1'b0;
    valid      = 1'b1;
    unique case (idx)
      {power_link_pkg::lvl_low, power_link_pkg::lvl_low}:   {cable_type, latch_edge, ctrl_proto} = 3'h7;
      {power_link_pkg::lvl_low, power_link_pkg::lvl_mid}:   {cable_type, latch_edge, ctrl_proto} = 3'h6;
      {power_link_pkg::lvl_low, power_link_pkg::lvl_high}:  {cable_type, latch_edge, ctrl_proto} = 3'h5;
      {power_link_pkg::lvl_mid, power_link_pkg::lvl_low}:   {cable_type, latch_edge, ctrl_proto} = 3'h4;
      {power_link_pkg::lvl_mid, power_link_pkg::lvl_mid}:   {cable_type, latch_edge, ctrl_proto} = 3'h3;
      {power_link_pkg::lvl_mid, power_link_pkg::lvl_high}:  {cable_type, latch_edge, ctrl_proto} = 3'h2;
      {power_link_pkg::lvl_high, power_link_pkg::lvl_low}:  {cable_type, latch_edge, ctrl_proto} = 3'h1;
      {power_link_pkg::lvl_high, power_link_pkg::lvl_mid}:  {cable_type, latch_edge, ctrl_proto} = 3'h0;
      // Both high or an unused code: reserved, no configuration
      default:                                              valid = 1'b0;
    endcase
  end

endmodule

// ==== hdl/wait_timer.sv ====
// Purpose: count a wait after a start pulse
// Assumes: one clock; a start pulse loads the count, each clock cycle decrements it
// Notes:   busy stays high for count clock cycles after start

module wait_timer #(
  parameter int count = 40000
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic clear,
  input  wire logic start,
  output logic      busy
);

  logic [31:0] left;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      left <= 32'h0;
    else if (clear)
      left <= 32'h0;
    else if (start)
      left <= 32'(count);
    else if (left != 32'h0)
      left <= left - 32'h1;
  end

  assign busy = (left != 32'h0);

endmodule

// ==== hdl/power_link_seq.sv ====
// Purpose: power mode and link bring-up sequencer with APB registers
// Assumes: pins synchronous to pclk; straps as 2-bit level codes
// Notes:   power-down acts as a synchronous register reset
//
// Behaviour
// - Straps decode into cable, edge, protocol defaults
// - Software may overwrite strap-derived settings
// - Control channel command enters or leaves sleep
// - Sleep bit set means sleep at once
// - Each output line has gated wake receiver
// - Positive receiver on, negative off at power-up
// - Both receivers off: only local or remote control channel commands wake
// - Power-down pin low: outputs high impedance
// - Power-down returns registers to reset
// - Leaving power-down latches all strap pins
// - Oscillator-clocked configuration link without pixel clock
// - Config link enable starts link until video
// - Serial enable gives video priority, locks
// - Control channel only after link established
// - Remote relocks after matching serializer bit
//
// The address map and the APB register port were left to the implementer.

module power_link_seq #(
  parameter int chan_wait = power_link_pkg::chan_wait_cyc,
  parameter int lock_wait = power_link_pkg::lock_wait_cyc
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        power_down_n,
  input  wire logic [1:0]  strap_cfg_hi,
  input  wire logic [1:0]  strap_cfg_lo,
  input  wire logic        width_strap_pin,
  input  wire logic        sync_encode_strap_pin,
  input  wire logic        local_ctrl_en_pin,
  input  wire logic        rx_data_strap_pin,
  input  wire logic        tx_clock_strap_pin,
  input  wire logic        pixel_clock_in,
  // Control channel events
  input  wire logic        ctrl_cmd_local,
  input  wire logic        ctrl_cmd_remote,
  input  wire logic        wake_rx_pos,
  input  wire logic        wake_rx_neg,
  input  wire logic        remote_power_up,
  input  wire logic        remote_locked,
  // Status and drive
  output logic             out_pos_oe,
  output logic             out_neg_oe,
  output logic             asleep,
  output logic             cfg_link_active,
  output logic             video_link_active,
  output logic             osc_tick,
  output logic             ctrl_chan_ready
);

  // ****************************************
  // Strap decode and latching
  // ****************************************
  logic       dec_cable;
  logic       dec_edge;
  logic       dec_proto;
  logic       dec_valid;
  logic       pd_prev;
  logic       relatch;
  logic [6:0] strap_latched;
  logic       strap_valid;

  strap_decode u_strap (
    .strap_cfg_hi (strap_cfg_hi),
    .strap_cfg_lo (strap_cfg_lo),
    .cable_type   (dec_cable),
    .latch_edge   (dec_edge),
    .ctrl_proto   (dec_proto),
    .valid        (dec_valid)
  );

  // Straps are caught by a clocked process after release, never under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pd_prev <= 1'b0;
    else
      pd_prev <= power_down_n;
  end

  assign relatch = power_down_n && !pd_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_latched <= 7'h0;
      strap_valid   <= 1'b0;
    end
    else if (relatch)
    begin
      strap_latched <= {width_strap_pin, sync_encode_strap_pin, local_ctrl_en_pin, rx_data_strap_pin,
                        tx_clock_strap_pin, strap_cfg_hi != 2'h0, strap_cfg_lo != 2'h0};
      strap_valid   <= dec_valid;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic ctrl_wr;
  logic link_wr;
  logic sleep;
  logic cable_type_sel;
  logic latch_edge_sel;
  logic ctrl_proto_sel;
  logic wake_rx_pos_en;
  logic wake_rx_neg_en;
  logic cfg_link_en;
  logic serial_link_en;
  logic rate_select;
  logic bus_width_sel;
  logic err_correct_sel;
  logic wake_event;
  logic sleep_cmd;

  assign ctrl_wr = psel && penable && pwrite && paddr == power_link_pkg::ctrl_off;
  assign link_wr = psel && penable && pwrite && paddr == power_link_pkg::link_off;

  // Receivers gated by enables; local and remote channel commands always wake
  assign wake_event = ctrl_cmd_local || ctrl_cmd_remote
                      || (wake_rx_pos && wake_rx_pos_en) || (wake_rx_neg && wake_rx_neg_en);
  assign sleep_cmd  = ctrl_wr && pwdata[power_link_pkg::sleep_bit];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cable_type_sel <= 1'b0;
      latch_edge_sel <= 1'b0;
      ctrl_proto_sel <= 1'b0;
      wake_rx_pos_en <= power_link_pkg::wake_pos_reset;
      wake_rx_neg_en <= power_link_pkg::wake_neg_reset;
    end
    else if (!power_down_n)
    begin
      cable_type_sel <= 1'b0;
      latch_edge_sel <= 1'b0;
      ctrl_proto_sel <= 1'b0;
      wake_rx_pos_en <= power_link_pkg::wake_pos_reset;
      wake_rx_neg_en <= power_link_pkg::wake_neg_reset;
    end
    else if (relatch && dec_valid)
    begin
      cable_type_sel <= dec_cable;
      latch_edge_sel <= dec_edge;
      ctrl_proto_sel <= dec_proto;
    end
    else if (ctrl_wr)
    begin
      cable_type_sel <= pwdata[power_link_pkg::cable_type_bit];
      latch_edge_sel <= pwdata[power_link_pkg::latch_edge_bit];
      ctrl_proto_sel <= pwdata[power_link_pkg::ctrl_proto_bit];
      wake_rx_pos_en <= pwdata[power_link_pkg::wake_pos_bit];
      wake_rx_neg_en <= pwdata[power_link_pkg::wake_neg_bit];
    end
  end

  // Sleep: a written 1 sleeps at once; a wake event lifts it, a write of 0 keeps it lifted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep <= 1'b0;
    else if (!power_down_n)
      sleep <= 1'b0;
    else if (ctrl_wr)
      sleep <= pwdata[power_link_pkg::sleep_bit];
    else if (wake_event)
      sleep <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_link_en     <= 1'b0;
      serial_link_en  <= 1'b0;
      rate_select     <= 1'b0;
      bus_width_sel   <= 1'b0;
      err_correct_sel <= 1'b0;
    end
    else if (!power_down_n)
    begin
      cfg_link_en     <= 1'b0;
      serial_link_en  <= 1'b0;
      rate_select     <= 1'b0;
      bus_width_sel   <= 1'b0;
      err_correct_sel <= 1'b0;
    end
    else if (relatch)
    begin
      bus_width_sel   <= width_strap_pin;
      err_correct_sel <= rx_data_strap_pin;
    end
    else if (link_wr)
    begin
      cfg_link_en     <= pwdata[power_link_pkg::cfg_link_bit];
      serial_link_en  <= pwdata[power_link_pkg::serial_link_bit];
      rate_select     <= pwdata[power_link_pkg::rate_bit];
      bus_width_sel   <= pwdata[power_link_pkg::width_bit];
      err_correct_sel <= pwdata[power_link_pkg::err_corr_bit];
    end
  end

  // ****************************************
  // Oscillator tick and link state
  // ****************************************
  logic [7:0]                  osc_cnt;
  logic                        osc_wrap;
  power_link_pkg::link_state_t state;
  power_link_pkg::link_state_t next_state;
  logic                        fmt_change;
  logic                        lock_busy;
  logic                        chan_busy;

  assign osc_wrap = osc_cnt == 8'(power_link_pkg::osc_div - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_cnt <= 8'h0;
    else if (osc_wrap)
      osc_cnt <= 8'h0;
    else
      osc_cnt <= osc_cnt + 8'h1;
  end

  // Changing a link format bit restarts the lock wait
  assign fmt_change = link_wr && ({pwdata[power_link_pkg::rate_bit], pwdata[power_link_pkg::width_bit],
                      pwdata[power_link_pkg::err_corr_bit]} != {rate_select, bus_width_sel, err_correct_sel});

  wait_timer #(
    .count (lock_wait)
  ) u_lock (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!power_down_n),
    .start   (fmt_change || (state == power_link_pkg::link_cfg_st && next_state == power_link_pkg::link_lock_st)),
    .busy    (lock_busy)
  );

  wait_timer #(
    .count (chan_wait)
  ) u_chan (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!power_down_n),
    .start   (remote_power_up),
    .busy    (chan_busy)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      power_link_pkg::link_off_st:
        if (serial_link_en && pixel_clock_in)
          next_state = power_link_pkg::link_lock_st;
        else if (cfg_link_en)
          next_state = power_link_pkg::link_cfg_st;
      power_link_pkg::link_cfg_st:
        if (serial_link_en && pixel_clock_in)
          next_state = power_link_pkg::link_lock_st;
        else if (!cfg_link_en)
          next_state = power_link_pkg::link_off_st;
      power_link_pkg::link_lock_st:
        if (!serial_link_en)
          next_state = cfg_link_en ? power_link_pkg::link_cfg_st : power_link_pkg::link_off_st;
        else if (remote_locked && !lock_busy)
          next_state = power_link_pkg::link_vid_st;
      power_link_pkg::link_vid_st:
        if (!serial_link_en)
          next_state = cfg_link_en ? power_link_pkg::link_cfg_st : power_link_pkg::link_off_st;
        else if (!remote_locked)
          next_state = power_link_pkg::link_lock_st;
      default:
        next_state = power_link_pkg::link_off_st;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= power_link_pkg::link_off_st;
    else if (!power_down_n || sleep_cmd)
      state <= power_link_pkg::link_off_st;
    else if (!sleep)
      state <= next_state;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_pos_oe        <= 1'b0;
      out_neg_oe        <= 1'b0;
      asleep            <= 1'b0;
      cfg_link_active   <= 1'b0;
      video_link_active <= 1'b0;
      osc_tick          <= 1'b0;
      ctrl_chan_ready   <= 1'b0;
    end
    else
    begin
      out_pos_oe        <= power_down_n && !sleep;
      out_neg_oe        <= power_down_n && !sleep && cable_type_sel;
      asleep            <= sleep || sleep_cmd;
      cfg_link_active   <= state == power_link_pkg::link_cfg_st && !pixel_clock_in;
      video_link_active <= state == power_link_pkg::link_vid_st;
      osc_tick          <= osc_wrap && state == power_link_pkg::link_cfg_st;
      ctrl_chan_ready   <= power_down_n && !chan_busy && !lock_busy
                           && (state == power_link_pkg::link_cfg_st || state == power_link_pkg::link_vid_st);
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != power_link_pkg::ctrl_off && paddr != power_link_pkg::link_off
                 && paddr != power_link_pkg::status_off && paddr != power_link_pkg::strap_off;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite)
        unique case (paddr)
          power_link_pkg::ctrl_off:
            prdata <= {26'h0, wake_rx_neg_en, wake_rx_pos_en, ctrl_proto_sel, latch_edge_sel, cable_type_sel, sleep};
          power_link_pkg::link_off:
            prdata <= {27'h0, err_correct_sel, bus_width_sel, rate_select, serial_link_en, cfg_link_en};
          power_link_pkg::status_off:
            prdata <= {25'h0, chan_busy, lock_busy, ctrl_chan_ready, state};
          power_link_pkg::strap_off:
            prdata <= {24'h0, strap_valid, strap_latched};
          default:
            prdata <= 32'h0;
        endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sleep_now_a : assert property (@(posedge pclk) disable iff (!presetn)
    power_down_n && sleep_cmd |=> asleep) else $error("sleep not immediate");
  pd_hiz_a : assert property (@(posedge pclk) disable iff (!presetn)
    !power_down_n |=> !out_pos_oe && !out_neg_oe) else $error("outputs driven in power-down");
  pd_reset_a : assert property (@(posedge pclk) disable iff (!presetn)
    !power_down_n |=> wake_rx_pos_en && !wake_rx_neg_en && !serial_link_en
    && !cable_type_sel && !sleep) else $error("no reset");
  wake_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    sleep && power_down_n && !ctrl_wr && !ctrl_cmd_local && !ctrl_cmd_remote && !wake_rx_pos_en && !wake_rx_neg_en
    |=> sleep) else $error("woken by disabled receiver");
  strap_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !relatch |=> $stable(strap_latched)) else $error("strap changed without release");
  chan_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_chan_ready |-> $past(!chan_busy)) else $error("channel ready during wait");
  video_pri_a : assert property (@(posedge pclk) disable iff (!presetn)
    state == power_link_pkg::link_cfg_st && serial_link_en && pixel_clock_in && power_down_n && !sleep && !sleep_cmd
    |=> state == power_link_pkg::link_lock_st) else $error("video link not preferred");
  reserved_a : assert property (@(posedge pclk) disable iff (!presetn)
    relatch && !dec_valid && !ctrl_wr |=> $stable(cable_type_sel)) else $error("reserved strap applied");

endmodule

// ==== bench/remote_model.sv ====
// Purpose: remote deserializer stand-in for wake, power-up and lock
// Assumes: all events launched just after pclk rising edges
// Notes:   lock returns eight cycles after a relock request

module remote_model
(
  // Clock
  input  wire logic pclk,
  // Events towards the serializer
  output logic      remote_power_up,
  output logic      remote_locked,
  output logic      wake_rx_pos,
  output logic      wake_rx_neg
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       want_lock;
  logic [2:0] lock_cnt;

  initial
  begin
    {remote_power_up, wake_rx_pos, wake_rx_neg, want_lock} = 4'h0;
  end

  // Lock drops at once, returns only after a settling delay
  always @(posedge pclk)
  begin
    if (!want_lock)
      {remote_locked, lock_cnt} <= 4'h0;
    else if (lock_cnt != 3'h7)
      lock_cnt <= lock_cnt + 3'h1;
    else
      remote_locked <= 1'b1;
  end

  task pulse(input logic [2:0] sel);
    @(posedge pclk);
    {remote_power_up, wake_rx_pos, wake_rx_neg} <= sel;
    @(posedge pclk);
    {remote_power_up, wake_rx_pos, wake_rx_neg} <= 3'h0;
    repeat (2) @(posedge pclk);
  endtask

  // Lock dropped for two cycles, then relock requested
  task relock();
    @(posedge pclk);
    want_lock <= 1'b0;
    repeat (2) @(posedge pclk);
    want_lock <= 1'b1;
  endtask
endmodule

// ==== bench/power_link_seq_tb.sv ====
// Purpose: self-checking bench for the power and link sequencer
// Assumes: short wait parameters, APB master with one idle cycle between transfers
// Notes:   strap table walked through power-down pulses

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module power_link_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, power_down_n, pixel_clock_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, ctrl_cmd_local, ctrl_cmd_remote;
  logic [1:0]  strap_cfg_hi, strap_cfg_lo;
  logic        width, sync, lcl, rxs, txs, remote_power_up, remote_locked, wake_rx_pos, wake_rx_neg;
  logic        out_pos_oe, out_neg_oe, asleep, cfg_link_active, video_link_active, osc_tick, ctrl_chan_ready;
  int          bad_count, total_checks, n, i;
  logic [2:0]  pec [9] = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4, 3'h0, 3'h0};

  power_link_seq #(.chan_wait(20), .lock_wait(30)) power_link_seq_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_down_n(power_down_n), .strap_cfg_hi(strap_cfg_hi),
    .strap_cfg_lo(strap_cfg_lo), .width_strap_pin(width), .sync_encode_strap_pin(sync),
    .local_ctrl_en_pin(lcl), .rx_data_strap_pin(rxs), .tx_clock_strap_pin(txs),
    .pixel_clock_in(pixel_clock_in), .ctrl_cmd_local(ctrl_cmd_local), .ctrl_cmd_remote(ctrl_cmd_remote),
    .wake_rx_pos(wake_rx_pos), .wake_rx_neg(wake_rx_neg), .remote_power_up(remote_power_up),
    .remote_locked(remote_locked), .out_pos_oe(out_pos_oe), .out_neg_oe(out_neg_oe), .asleep(asleep),
    .cfg_link_active(cfg_link_active), .video_link_active(video_link_active), .osc_tick(osc_tick),
    .ctrl_chan_ready(ctrl_chan_ready));

  remote_model remote_model_i (.pclk(pclk), .remote_power_up(remote_power_up),
    .remote_locked(remote_locked), .wake_rx_pos(wake_rx_pos), .wake_rx_neg(wake_rx_neg));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************
  // Bus and pin tasks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    `CHK("pready", 1'b1, pready)
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task cmd(input logic [1:0] s);
    @(posedge pclk);
    {ctrl_cmd_local, ctrl_cmd_remote} <= s;
    @(posedge pclk);
    {ctrl_cmd_local, ctrl_cmd_remote} <= 2'b00;
    repeat (2) @(posedge pclk);
  endtask

  task pd();
    @(posedge pclk);
    power_down_n <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("oe in power-down", 2'b00, {out_pos_oe, out_neg_oe})
    power_down_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn, pixel_clock_in} = '0;
    {strap_cfg_hi, strap_cfg_lo, width, sync, lcl, rxs, txs, ctrl_cmd_local, ctrl_cmd_remote} = '0;
    power_down_n = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(power_link_pkg::ctrl_off, 32'h1e, "ctrl reset");
    apb(1'b1, power_link_pkg::ctrl_off, 32'h3f);
    apb(1'b1, power_link_pkg::link_off, 32'h1f);
    for (i = 0; i < 9; i++)
    begin
      {strap_cfg_hi, strap_cfg_lo} <= {2'(i / 3), 2'(i % 3)};
      {width, sync, lcl, rxs, txs} <= {i[0], i[1], i[2], i[3], ~i[0]};
      pd();
      rchk(power_link_pkg::ctrl_off, {26'h0, 2'b01, pec[i], 1'b0}, "ctrl defaults");
      rchk(power_link_pkg::strap_off, {24'h0, i != 8, i[0], i[1], i[2], i[3], ~i[0], i / 3 != 0,
        i % 3 != 0}, "strap latch");
      rchk(power_link_pkg::link_off, {27'h0, i[3], i[0], 3'h0}, "link defaults");
    end
    apb(1'b1, power_link_pkg::ctrl_off, 32'h2e);
    rchk(power_link_pkg::ctrl_off, 32'h2e, "ctrl override");
    apb(1'b1, power_link_pkg::ctrl_off, 32'h2f);
    repeat (2) @(posedge pclk);
    `CHK("asleep", 1'b1, asleep)
    remote_model_i.pulse(3'b010);
    `CHK("disabled receiver", 1'b1, asleep)
    remote_model_i.pulse(3'b001);
    `CHK("enabled receiver", 1'b0, asleep)
    apb(1'b1, power_link_pkg::ctrl_off, 32'h0f);
    remote_model_i.pulse(3'b011);
    `CHK("receivers off", 1'b1, asleep)
    cmd(2'b10);
    `CHK("local wake", 1'b0, asleep)
    apb(1'b1, power_link_pkg::ctrl_off, 32'h0f);
    cmd(2'b01);
    `CHK("remote wake", 1'b0, asleep)
    apb(1'b1, power_link_pkg::ctrl_off, 32'h0e);
    apb(1'b1, power_link_pkg::link_off, 32'h01);
    repeat (3) @(posedge pclk);
    `CHK("cfg link", 1'b1, cfg_link_active)
    n = 0;
    repeat (100)
    begin
      @(posedge pclk);
      n += osc_tick;
    end
    `CHK("osc ticks", 5, n)
    n = 0;
    while (ctrl_chan_ready !== 1'b1 && n++ < 50) @(posedge pclk);
    `CHK("chan ready", 1'b1, ctrl_chan_ready)
    remote_model_i.pulse(3'b100);
    `CHK("chan wait", 1'b0, ctrl_chan_ready)
    n = 0;
    while (ctrl_chan_ready !== 1'b1 && n++ < 40) @(posedge pclk);
    `CHK("chan back", 1'b1, ctrl_chan_ready)
    apb(1'b1, power_link_pkg::link_off, 32'h03);
    repeat (3) @(posedge pclk);
    `CHK("no pixel clock", 1'b1, cfg_link_active)
    pixel_clock_in <= 1'b1;
    remote_model_i.relock();
    apb(1'b1, power_link_pkg::link_off, 32'h03);
    repeat (3) @(posedge pclk);
    `CHK("cfg overridden", 1'b0, cfg_link_active)
    apb(1'b0, power_link_pkg::status_off, 32'h0);
    `CHK("lock state", 4'h4, rd[3:0])
    n = 0;
    while (video_link_active !== 1'b1 && n++ < 100) @(posedge pclk);
    `CHK("video", 1'b1, video_link_active)
    remote_model_i.relock();
    apb(1'b1, power_link_pkg::link_off, 32'h0b);
    n = 0;
    while ({video_link_active, ctrl_chan_ready} !== 2'b11 && n++ < 100) @(posedge pclk);
    `CHK("relocked", 2'b11, {video_link_active, ctrl_chan_ready})
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    report_and_stop();
  end
endmodule
